// ==== core/ati_pkg.sv ====
/*
  Shared constants and types for the actuator teach-in block: identity width, variant codes,
  indicator modes, state encoding and every timing figure with its derived cycle count.
  Assumes a single 20 MHz clock; every cycle count except ATI_QPERIOD_CYC reaches the modules as an overridable parameter.
*/
package ati_pkg;

  localparam int ATI_ID_W = 32;
  localparam int ATI_HIST_N = 8;
  localparam logic [3:0] ATI_RELEARN_MAX = 4'h8;
  localparam logic [3:0] ATI_HIST_RST = 4'h0;

  // Product variant, strapped on the variant input.
  localparam logic [1:0] ATI_VAR_FREE = 2'h0;
  localparam logic [1:0] ATI_VAR_RELEARN = 2'h1;
  localparam logic [1:0] ATI_VAR_ONCE = 2'h2;

  // Gate indicator modes.
  localparam logic [1:0] ATI_FL_OFF = 2'h0;
  localparam logic [1:0] ATI_FL_ON = 2'h1;
  localparam logic [1:0] ATI_FL_SLOW = 2'h2;
  localparam logic [1:0] ATI_FL_QUICK = 2'h3;

  typedef enum logic [1:0] {ATI_BOOT, ATI_IDLE, ATI_DWELL, ATI_WINDOW} ati_state_t;

  localparam longint unsigned ATI_CLK_HZ = 20_000_000;
  localparam longint unsigned ATI_DWELL_S = 20;
  localparam longint unsigned ATI_WINDOW_S = 120;
  localparam longint unsigned ATI_SLOW_ON_MS = 500;
  localparam longint unsigned ATI_SLOW_OFF_MS = 500;
  localparam longint unsigned ATI_QUICK_ON_MS = 50;
  localparam longint unsigned ATI_QUICK_OFF_MS = 950;

  localparam longint unsigned ATI_DWELL_CYC = ATI_DWELL_S * ATI_CLK_HZ;
  localparam longint unsigned ATI_WINDOW_CYC = ATI_WINDOW_S * ATI_CLK_HZ;
  localparam longint unsigned ATI_SLOW_ON_CYC = ATI_SLOW_ON_MS * ATI_CLK_HZ / 1000;
  localparam longint unsigned ATI_QUICK_ON_CYC = ATI_QUICK_ON_MS * ATI_CLK_HZ / 1000;
  localparam longint unsigned ATI_PERIOD_CYC = (ATI_SLOW_ON_MS + ATI_SLOW_OFF_MS) * ATI_CLK_HZ / 1000;
  localparam longint unsigned ATI_QPERIOD_CYC = (ATI_QUICK_ON_MS + ATI_QUICK_OFF_MS) * ATI_CLK_HZ / 1000;

endpackage

// ==== core/ati_flash.sv ====
/*
  Gate indicator pattern generator: off, steady, slow flash or quick flash, both flashes with a
  one-second period that restarts with the on phase whenever the requested mode changes.
  Assumes the mode input comes from a flip-flop of the same clock domain.
*/
`timescale 1ns/10ps
module ati_flash
  import ati_pkg::*;
#(
  parameter logic [24:0] PERIOD_CYC = 25'(ATI_PERIOD_CYC),
  parameter logic [24:0] SLOW_ON_CYC = 25'(ATI_SLOW_ON_CYC),
  parameter logic [24:0] QUICK_ON_CYC = 25'(ATI_QUICK_ON_CYC)
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  output logic led
);

  typedef struct packed {
    logic [1:0] mode;
    logic [24:0] cnt;
    logic led;
  } ati_flash_st_t;

  ati_flash_st_t q;
  ati_flash_st_t d;

  always_comb
  begin
    d = q;
    d.mode = mode;
    if (mode != q.mode || q.cnt == PERIOD_CYC - 25'h1)
    begin
      d.cnt = 25'h0;
    end
    else
    begin
      d.cnt = q.cnt + 25'h1;
    end
    case (d.mode)
      ATI_FL_ON: d.led = 1'b1;
      ATI_FL_SLOW: d.led = d.cnt < SLOW_ON_CYC; // [RL12]
      ATI_FL_QUICK: d.led = d.cnt < QUICK_ON_CYC; // [RL13]
      default: d.led = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      q <= '{mode: ATI_FL_OFF, cnt: 25'h0, led: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign led = q.led;

  property p_slow_phase;
    @(posedge ref_clk) disable iff (!rst_n)
    q.mode == ATI_FL_SLOW |-> q.led == (q.cnt < SLOW_ON_CYC);
  endproperty
  a_slow_phase: assert property (p_slow_phase) else $error("slow flash phase wrong"); // [RL12]

  property p_quick_phase;
    @(posedge ref_clk) disable iff (!rst_n)
    q.mode == ATI_FL_QUICK |-> q.led == (q.cnt < QUICK_ON_CYC);
  endproperty
  a_quick_phase: assert property (p_quick_phase) else $error("quick flash phase wrong"); // [RL13]

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.cnt == PERIOD_CYC - 25'h1 && mode == q.mode)
      |=> q.cnt == 25'h0 && led == (q.mode != ATI_FL_OFF);
  endproperty
  a_wrap: assert property (p_wrap) else $error("flash period did not wrap"); // [RL13]

endmodule

// ==== core/ati_teach.sv ====
/*
  Actuator teach-in control of a transponder safety switch: acceptance per variant, automatic
  first learn, the timed relearn sequence with its supply-cycle confirmation, and the history of
  replaced actuators. The learned identity, relearn budget, history and pending confirmation
  model non-volatile memory: rst_n (power-on) leaves them alone; factory_clr initialises them.
  Assumes act_present and act_id are synchronous to ref_clk and that variant is a static strap.
*/
`timescale 1ns/10ps
// Contract
// [RL1] Unrestricted variant accepts any compatible actuator in range, no learning.
// [RL2] Learning variants store the first detected actuator when none is learned.
// [RL3] Relearnable variant counts remaining relearns, at most eight over life.
// [RL4] During relearn the new actuator is the only transponder in range.
// [RL5] New unlearned actuator detected: gate indicator flashes yellow slowly.
// [RL6] After 20 s continuous detection, switch to quick flash and open window.
// [RL7] Operator confirms by interrupting supply within 120 s of quick flash.
// [RL8] Next power-up adopts the new actuator and decrements the count by one.
// [RL9] Actuator stays in range until the confirming power-up completes.
// [RL10] A previously learned, since replaced actuator can never be relearned.
// [RL11] Single-learn variant refuses any other actuator after the first.
// [RL12] Slow flash is 500 ms on, 500 ms off.
// [RL13] Quick flash is 50 ms on, 950 ms off.
// [RL14] Leaving range, window expiry or zero budget abandons relearn, keeps old.
module ati_teach
  import ati_pkg::*;
#(
  parameter logic [31:0] DWELL_CYC = 32'(ATI_DWELL_CYC),
  parameter logic [31:0] WINDOW_CYC = 32'(ATI_WINDOW_CYC),
  parameter logic [24:0] PERIOD_CYC = 25'(ATI_PERIOD_CYC),
  parameter logic [24:0] SLOW_ON_CYC = 25'(ATI_SLOW_ON_CYC),
  parameter logic [24:0] QUICK_ON_CYC = 25'(ATI_QUICK_ON_CYC)
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] variant,
  input wire logic factory_clr,
  input wire logic act_present,
  input wire logic [ATI_ID_W-1:0] act_id,
  output logic act_valid,
  output logic gate_led,
  output logic teach_busy,
  output logic [3:0] relearn_left
);

  typedef struct packed {
    ati_state_t state;
    logic [31:0] timer;
    logic [ATI_ID_W-1:0] cand_id;
    logic valid;
    logic [1:0] led_mode;
    logic busy;
    logic [3:0] left_out;
    logic learned;
    logic [ATI_ID_W-1:0] learned_id;
    logic [3:0] left;
    logic [3:0] hist_n;
    logic [ATI_HIST_N-1:0][ATI_ID_W-1:0] hist;
    logic pend;
    logic [ATI_ID_W-1:0] pend_id;
  } ati_teach_st_t;

  ati_teach_st_t q;
  ati_teach_st_t d;
  logic hit_hist;
  logic known;
  logic cand_ok;

  function automatic logic ati_in_hist(input logic [ATI_ID_W-1:0] id,
                                       input logic [ATI_HIST_N-1:0][ATI_ID_W-1:0] hist,
                                       input logic [3:0] n);
    logic found;
    found = 1'b0;
    for (int i = 0; i < ATI_HIST_N; i++)
    begin
      if (4'(i) < n && hist[i] == id)
      begin
        found = 1'b1;
      end
    end
    return found;
  endfunction

  assign hit_hist = ati_in_hist(act_id, q.hist, q.hist_n);
  assign known = q.learned && act_id == q.learned_id;
  assign cand_ok = act_present && act_id == q.cand_id;

  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    case (q.state)
      ATI_BOOT:
      begin
        // The pending confirmation is consumed by this power-up whether or not it adopts.
        if (q.pend && variant == ATI_VAR_RELEARN && act_present && act_id == q.pend_id
            && q.left != 4'h0 && q.hist_n < 4'(ATI_HIST_N))
        begin
          d.hist[q.hist_n[2:0]] = q.learned_id; // [RL10]
          d.hist_n = q.hist_n + 4'h1;
          d.learned_id = q.pend_id; // [RL8]
          d.left = q.left - 4'h1; // [RL8] [RL3]
        end
        d.pend = 1'b0; // [RL9] [RL14]
        d.state = ATI_IDLE;
      end
      ATI_IDLE:
      begin
        d.valid = act_present && (variant == ATI_VAR_FREE || known); // [RL1]
        if (variant != ATI_VAR_FREE && act_present && !q.learned && !hit_hist)
        begin
          d.learned = 1'b1; // [RL2]
          d.learned_id = act_id; // [RL2]
        end
        else if (variant == ATI_VAR_RELEARN && act_present && q.learned && !known && !hit_hist
                 && q.left != 4'h0)
        begin
          // Refusing ids in the history and a spent budget keeps the old actuator. [RL10] [RL14] [RL11]
          d.state = ATI_DWELL; // [RL5]
          d.cand_id = act_id;
          d.timer = 32'h0;
        end
      end
      ATI_DWELL:
      begin
        // A second transponder shows as a changed id and abandons the sequence to idle. [RL4]
        if (!cand_ok)
        begin
          d.state = ATI_IDLE; // [RL14]
        end
        else if (q.timer == DWELL_CYC - 32'h1)
        begin
          d.state = ATI_WINDOW; // [RL6]
          d.timer = 32'h0;
          d.pend = 1'b1; // [RL6] [RL7]
          d.pend_id = q.cand_id;
        end
        else
        begin
          d.timer = q.timer + 32'h1;
        end
      end
      ATI_WINDOW:
      begin
        if (!cand_ok || q.timer == WINDOW_CYC - 32'h1)
        begin
          d.state = ATI_IDLE; // [RL14]
          d.pend = 1'b0; // [RL14] [RL7]
        end
        else
        begin
          d.timer = q.timer + 32'h1;
        end
      end
      default:
      begin
        d.state = ATI_BOOT;
      end
    endcase
    if (factory_clr)
    begin
      d.state = ATI_IDLE;
      d.learned = 1'b0;
      d.learned_id = '0;
      d.left = ATI_RELEARN_MAX; // [RL3]
      d.hist_n = ATI_HIST_RST;
      d.hist = '0;
      d.pend = 1'b0;
      d.pend_id = '0;
      d.valid = 1'b0;
    end
    d.busy = d.state == ATI_DWELL || d.state == ATI_WINDOW;
    d.left_out = d.left;
    case (d.state)
      ATI_DWELL: d.led_mode = ATI_FL_SLOW; // [RL5]
      ATI_WINDOW: d.led_mode = ATI_FL_QUICK; // [RL6]
      default: d.led_mode = act_present ? ATI_FL_ON : ATI_FL_OFF;
    endcase
  end

  // Retained fields are deliberately kept through rst_n, as a supply cycle would keep them.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      q.state <= ATI_BOOT;
      q.timer <= 32'h0;
      q.cand_id <= '0;
      q.valid <= 1'b0;
      q.led_mode <= ATI_FL_OFF;
      q.busy <= 1'b0;
      q.left_out <= 4'h0;
    end
    else
    begin
      q <= d;
    end
  end

  ati_flash #(
    .PERIOD_CYC(PERIOD_CYC),
    .SLOW_ON_CYC(SLOW_ON_CYC),
    .QUICK_ON_CYC(QUICK_ON_CYC)
  ) u_flash (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .mode(q.led_mode),
    .led(gate_led)
  );

  assign act_valid = q.valid;
  assign teach_busy = q.busy;
  assign relearn_left = q.left_out;

  sequence s_dwell_done;
    q.state == ATI_DWELL && cand_ok && q.timer == DWELL_CYC - 32'h1 && !factory_clr;
  endsequence

  sequence s_window_open;
    q.state == ATI_WINDOW && q.pend && q.pend_id == $past(q.cand_id) && q.led_mode == ATI_FL_QUICK;
  endsequence

  sequence s_boot_adopt;
    q.state == ATI_BOOT && q.pend && variant == ATI_VAR_RELEARN && act_present
      && act_id == q.pend_id && q.left != 4'h0 && q.hist_n < 4'h8 && !factory_clr;
  endsequence

  property p_free;
    @(posedge ref_clk) disable iff (!rst_n)
    (variant == ATI_VAR_FREE && act_present && q.state == ATI_IDLE && !factory_clr) |=> act_valid;
  endproperty
  a_free: assert property (p_free) else $error("free variant did not accept"); // [RL1]

  property p_first;
    @(posedge ref_clk) disable iff (!rst_n)
    (variant != ATI_VAR_FREE && q.state == ATI_IDLE && act_present && !q.learned && !hit_hist
     && !factory_clr) |=> q.learned && q.learned_id == $past(act_id) ##1 act_valid || !act_present;
  endproperty
  a_first: assert property (p_first) else $error("first actuator not learned"); // [RL2]

  property p_left_mono;
    @(posedge ref_clk) disable iff (!rst_n)
    !factory_clr |=> q.left <= $past(q.left) && q.left <= ATI_RELEARN_MAX;
  endproperty
  a_left_mono: assert property (p_left_mono) else $error("relearn budget rose or overflowed"); // [RL3]

  property p_slow;
    @(posedge ref_clk) disable iff (!rst_n)
    q.state == ATI_DWELL |-> q.led_mode == ATI_FL_SLOW && q.busy;
  endproperty
  a_slow: assert property (p_slow) else $error("detection not shown as slow flash"); // [RL5]

  property p_window;
    @(posedge ref_clk) disable iff (!rst_n)
    s_dwell_done |=> s_window_open;
  endproperty
  a_window: assert property (p_window) else $error("window not opened after dwell"); // [RL6]

  property p_adopt;
    @(posedge ref_clk) disable iff (!rst_n)
    s_boot_adopt |=> q.learned_id == $past(q.pend_id) && q.left == $past(q.left) - 4'h1 && !q.pend;
  endproperty
  a_adopt: assert property (p_adopt) else $error("confirmed actuator not adopted"); // [RL8]

  property p_hist_block;
    @(posedge ref_clk) disable iff (!rst_n)
    (q.state == ATI_IDLE && act_present && hit_hist) |=> q.state != ATI_DWELL;
  endproperty
  a_hist_block: assert property (p_hist_block) else $error("replaced actuator accepted for relearn"); // [RL10]

  property p_once;
    @(posedge ref_clk) disable iff (!rst_n)
    (variant == ATI_VAR_ONCE && q.learned && !factory_clr) |=> $stable(q.learned_id) && q.state != ATI_DWELL;
  endproperty
  a_once: assert property (p_once) else $error("single-learn variant relearned"); // [RL11]

  property p_abandon;
    @(posedge ref_clk) disable iff (!rst_n)
    ((q.state == ATI_DWELL || q.state == ATI_WINDOW) && !act_present)
      |=> q.state == ATI_IDLE && !q.pend && $stable(q.learned_id);
  endproperty
  a_abandon: assert property (p_abandon) else $error("relearn not abandoned on removal"); // [RL14]

endmodule

// ==== dv/ati_actuator.sv ====
/*
  Behavioural transponder actuator standing in the response range of the teach-in block.
  Assumes the bench changes its commands away from the rising edge of ref_clk.
*/
`timescale 1ns/10ps
module ati_actuator
  import ati_pkg::*;
(
  input wire logic ref_clk,
  input wire logic want,
  input wire logic [ATI_ID_W-1:0] want_id,
  output logic act_present,
  output logic [ATI_ID_W-1:0] act_id
);
  // Only one transponder is ever in range, held there while the bench keeps it.
  always_ff @(posedge ref_clk)
  begin
    act_present <= want;
    // An absent tag gives no identity, so the bus shows the inverse to keep stale ids from matching.
    act_id <= want ? want_id : ~want_id;
  end
endmodule

// ==== dv/ati_teach_tb.sv ====
/*
  Self-checking bench for the teach-in block with shortened timing counts.
  Assumes the design's own assertions run alongside; ids come from a fixed seed.
*/
`timescale 1ns/10ps
module ati_teach_tb import ati_pkg::*;;
  localparam int DW = 20;
  localparam int WN = 40;
  localparam int PER = 10;
  localparam int SON = 5;
  localparam int QON = 1;
  logic ref_clk, rst_n, factory_clr, want, act_present, act_valid, gate_led, teach_busy;
  logic [1:0] variant;
  logic [ATI_ID_W-1:0] want_id, act_id, id_a, id_b, id_c;
  logic [3:0] relearn_left;
  int n_mismatch = 0;
  int compares = 0;
  int n;

  ati_teach #(.DWELL_CYC(32'h14), .WINDOW_CYC(32'h28), .PERIOD_CYC(25'ha), .SLOW_ON_CYC(25'h5),
    .QUICK_ON_CYC(25'h1)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .variant(variant),
    .factory_clr(factory_clr), .act_present(act_present), .act_id(act_id), .act_valid(act_valid),
    .gate_led(gate_led), .teach_busy(teach_busy), .relearn_left(relearn_left));

  ati_actuator u_act (.ref_clk(ref_clk), .want(want), .want_id(want_id), .act_present(act_present),
    .act_id(act_id));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task complete_run;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Off time of a flash pattern is what remains of the shared period.
  function automatic int exp_off(input int on_cyc);
    return PER - on_cyc;
  endfunction

  // Budget left after the given number of confirmed relearns since the factory clear.
  function automatic int exp_left(input int used);
    return int'(ATI_RELEARN_MAX) - used;
  endfunction

  // Sampling 1 ns after the edge lets that edge's updates settle first.
  task cyc(input int k);
    repeat (k)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  task present(input logic [31:0] id);
    want = 1'b1;
    want_id = id;
  endtask

  task absent;
    want = 1'b0;
    cyc(3);
  endtask

  task wait_valid(input logic v, input int lim);
    for (int i = 0; i < lim && act_valid !== v; i++) cyc(1);
  endtask

  task wait_busy(input int lim);
    for (int i = 0; i < lim && teach_busy !== 1'b1; i++) cyc(1);
  endtask

  task power_cycle;
    @(posedge ref_clk) rst_n <= 1'b0;
    @(posedge ref_clk) rst_n <= 1'b1;
    cyc(1);
  endtask

  task setup(input logic [1:0] v);
    @(posedge ref_clk);
    variant <= v;
    factory_clr <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk) factory_clr <= 1'b0;
    power_cycle();
    cyc(2);
  endtask

  task pulse(output int hi, output int lo);
    for (int i = 0; i < 30 && gate_led !== 1'b1; i++) cyc(1);
    hi = 0;
    lo = 0;
    while (gate_led === 1'b1 && hi < 40)
    begin
      hi++;
      cyc(1);
    end
    while (gate_led === 1'b0 && lo < 40)
    begin
      lo++;
      cyc(1);
    end
  endtask

  // Full relearn of id, confirmed by a supply cycle inside the window.
  task teach(input logic [31:0] id, input logic [3:0] left);
    int hi, lo;
    present(id);
    wait_busy(6);
    check("busy_on_new", teach_busy, 1);
    pulse(hi, lo);
    check("slow_on", hi, SON);
    check("slow_off", lo, exp_off(SON));
    for (int i = 0; i < 4 && hi != QON; i++) pulse(hi, lo);
    check("quick_on", hi, QON);
    check("quick_off", lo, exp_off(QON));
    power_cycle();
    wait_valid(1'b1, 6);
    check("new_valid", act_valid, 1);
    check("budget", relearn_left, left - 1);
    absent();
  endtask

  initial
  begin
    cyc(20000);
    n_mismatch++;
    $display("watchdog expired");
    complete_run();
  end

  initial
  begin
    rst_n = 1'b0;
    // Retained memory is unknown until cleared, so the clear already stands when reset lets go.
    factory_clr = 1'b1;
    variant = ATI_VAR_FREE;
    want = 1'b0;
    want_id = '0;
    void'($urandom(86));
    id_a = $urandom;
    id_b = $urandom;
    id_c = $urandom;
    cyc(3);
    check("rst_left", relearn_left, 0);
    @(posedge ref_clk) rst_n <= 1'b1;
    setup(ATI_VAR_FREE);
    repeat (4)
    begin
      present($urandom);
      wait_valid(1'b1, 4);
      check("free_valid", act_valid, 1);
      check("free_busy", teach_busy, 0);
      absent();
      check("free_drop", act_valid, 0);
    end
    $display("test free done");
    setup(ATI_VAR_RELEARN);
    check("left_init", relearn_left, exp_left(0));
    present(id_a);
    wait_valid(1'b1, 6);
    check("first_learn", act_valid, 1);
    absent();
    teach(id_b, 4'h8);
    present(id_a);
    cyc(6);
    check("old_busy", teach_busy, 0);
    check("old_valid", act_valid, 0);
    absent();
    present(id_c);
    wait_busy(6);
    cyc(5);
    absent();
    check("leave_abandon", teach_busy, 0);
    present(id_c);
    wait_busy(6);
    n = 0;
    while (teach_busy === 1'b1 && n < 100)
    begin
      n++;
      cyc(1);
    end
    check("window_len", n, DW + WN);
    // Id stays present so a stale pending confirm would be adopted here.
    cyc(2);
    power_cycle();
    cyc(2);
    check("expired_valid", act_valid, 0);
    check("expired_left", relearn_left, exp_left(1));
    absent();
    present(id_b);
    wait_valid(1'b1, 4);
    check("kept_old", act_valid, 1);
    absent();
    $display("test relearn done");
    for (int k = 7; k > 0; k--) teach($urandom, 4'(k));
    present(id_c);
    cyc(6);
    check("zero_budget", teach_busy, 0);
    absent();
    $display("test budget done");
    setup(ATI_VAR_ONCE);
    present(id_a);
    wait_valid(1'b1, 6);
    check("once_first", act_valid, 1);
    absent();
    present(id_b);
    cyc(6);
    check("once_busy", teach_busy, 0);
    check("once_valid", act_valid, 0);
    absent();
    $display("test single done");
    complete_run();
  end
endmodule
